// File: lpm_pkg.sv
`default_nettype none
package lpm_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_SUPPLY_MON  = 8'h70;
    localparam logic [7:0] ADDR_POWER_CTRL  = 8'h60;
    // supply monitor field positions
    localparam int NOM_IE_BIT   = 0;
    localparam int HIGH_IE_BIT  = 1;
    localparam int NOM_FLAG_BIT = 2;
    localparam int HIGH_FLAG_BIT = 3;
    localparam int LOCK_BIT     = 4;
    localparam int RST_EN_BIT   = 5;
    localparam int REFBYPASS_DISABLE_BIT   = 15;
    // power control field positions
    localparam int SLEEP_RECOVERY_FLAG_BIT   = 0;
    localparam int STOPF_BIT    = 1;
    localparam int SLEEP_REQ_BIT = 16;
    localparam int STOP_REQ_BIT = 17;
    localparam int RELEASE_BIT  = 19;
    localparam int RETENTION_RAM_SELECT_LSB   = 20;
    localparam int RETENTION_RAM_SELECT_W     = 3;
    // reset values
    localparam logic RST_EN_RESET = 1'b1;
    localparam logic RESET_ZERO   = 1'b0;
    // controller oscillator rate; sleep power-up reset pulse is counted at 10 cycles per us, not from OSC_MHZ
    localparam int OSC_MHZ        = 16;
    localparam int PWRUP_RESET_NS = 1000;
    localparam int PWRUP_CYCLES   = (PWRUP_RESET_NS * 10) / 1000;
    // sequencer states
    typedef enum logic [2:0] {
        ST_RUN     = 3'b000,
        ST_ENTER   = 3'b001,
        ST_SLEEP   = 3'b010,
        ST_STOP    = 3'b011,
        ST_PWRUP   = 3'b100
    } lpm_state_t;
endpackage
`default_nettype wire

// File: low_power_mode_sequencer.sv
// What this block does
// [R1] flag interrupt only while its enable set
// [R2] nominal flag sets on low supply, w1c
// [R3] high flag sets on low supply, w1c
// [R4] lock blocks reset-enable writes until power-on
// [R5] reset-enable makes nominal flag cause reset
// [R6] bypass-disable bit turns reference pin off
// [R7] lock, enable reset by reset pin and supply_reset, not the 5 V detector
// [R8] two modes: sleep powers down, stop static
// [R9] drive latch, select and isolation pad controls
// [R10] cores execute wait to start entry
// [R11] enter on clock block signal, sleep wins
// [R12] modes only entered from and left to run
// [R13] controller clocked from oscillator until wakeup
// [R14] software selects clocks before wait
// [R15] software sets ram retention before wait
// [R16] stop exit releases keepers automatically
// [R17] sleep exit keepers held until release write
// [R18] re-entry with held keepers relatches pins
// [R19] reset pin or power-on returns to run
// [R20] sleep power-up asserts reset, sets flag
// [R21] sleep recovery skips boot pin and assist
// [R22] crystal disabled in low power, restarted after
// [R23] request bits cleared on matching mode exit
// [R24] keeper release write-only, reads zero
// [R25] detector outputs synchronised before flag set
//
// The plain strobed port and the placing of the registers were left to the implementer.
`default_nettype none
module low_power_mode_sequencer
    import lpm_pkg::*;
#(
    parameter int PWRUP_LEN = PWRUP_CYCLES   // sleep power-up reset length
) (
    input  wire logic        mclk,
    input  wire logic        reset,            // reset pin or power-on
    input  wire logic        supply_reset,     // other supply detector resets
    input  wire logic        supply5_low_reset, // 5 V detector reset
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        det_nominal_low,  // async detector outputs
    input  wire logic        det_high_low,
    input  wire logic        cores_halted,     // clock block: enter now
    input  wire logic        wakeup,
    input  wire logic        crystal_osc_enable,
    output logic             supply5_nominal_irq,
    output logic             supply5_high_irq,
    output logic             supply5_reset_req,
    output logic             converter_reference_bypass_pin,
    output logic             sleep_power_off,
    output logic             stop_static,
    output logic             pad_latch,
    output logic             pad_select_latched,
    output logic             pad_isolate,
    output logic             osc_clock_select,
    output logic             crystal_run,
    output logic             poweron_reset_out,
    output logic             skip_boot,
    output logic [2:0]       retention_ram_select
);
    import lpm_pkg::*;

    lpm_state_t state_r;                 // sequencer state
    logic [1:0] nom_sync_r, high_sync_r; // two-flop synchronisers
    logic       nom_d_r, high_d_r;       // edge history after sync
    logic       nom_ie_r, high_ie_r;
    logic       nom_flag_r, high_flag_r;
    logic       lock_r, rst_en_r, refbypass_disable_r;
    logic       sleep_req_r, stop_req_r;
    logic       sleep_recovery_flag_r, stopf_r;
    logic       keepers_r;               // pad keepers holding
    logic [2:0] retention_ram_select_r;
    logic [15:0] pw_cnt_r;
    logic       wr_mon, wr_pwr, nom_set, high_set, any_reset, bypass_reset;

    assign wr_mon   = wr && (addr == ADDR_SUPPLY_MON);
    assign wr_pwr   = wr && (addr == ADDR_POWER_CTRL);
    assign nom_set  = nom_sync_r[1] && !nom_d_r;    // R25
    assign high_set = high_sync_r[1] && !high_d_r;  // R25
    assign any_reset = reset || supply_reset;
    assign bypass_reset = any_reset || supply5_low_reset;

    // synchronise detector levels; first stage only feeds second
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            nom_sync_r  <= 2'h0;
            high_sync_r <= 2'h0;
            nom_d_r     <= 1'b0;
            high_d_r    <= 1'b0;
        end else begin
            nom_sync_r  <= {nom_sync_r[0], det_nominal_low};   // R25
            high_sync_r <= {high_sync_r[0], det_high_low};     // R25
            nom_d_r     <= nom_sync_r[1];
            high_d_r    <= high_sync_r[1];
        end
    end

    // interrupt enables
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            nom_ie_r  <= 1'b0;
            high_ie_r <= 1'b0;
        end else if (wr_mon) begin
            nom_ie_r  <= wdata[NOM_IE_BIT];
            high_ie_r <= wdata[HIGH_IE_BIT];
        end
    end

    // sticky flags; a set in the clear cycle wins
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            nom_flag_r  <= 1'b0;
            high_flag_r <= 1'b0;
        end else begin
            if (nom_set)
                nom_flag_r <= 1'b1;                            // R2
            else if (wr_mon && wdata[NOM_FLAG_BIT])
                nom_flag_r <= 1'b0;                            // R2
            if (high_set)
                high_flag_r <= 1'b1;                           // R3
            else if (wr_mon && wdata[HIGH_FLAG_BIT])
                high_flag_r <= 1'b0;                           // R3
        end
    end

    // lock and reset enable: reset pin and supply_reset reach them, not the 5 V detector
    always_ff @(posedge mclk or posedge any_reset) begin
        if (any_reset) begin                                   // R7
            lock_r   <= RESET_ZERO;
            rst_en_r <= RST_EN_RESET;
        end else if (wr_mon) begin
            if (wdata[LOCK_BIT])
                lock_r <= 1'b1;                                // R4
            if (!lock_r)
                rst_en_r <= wdata[RST_EN_BIT];                 // R4
        end
    end

    // bypass disable also cleared by the 5 V detector
    always_ff @(posedge mclk or posedge bypass_reset) begin
        if (bypass_reset)
            refbypass_disable_r <= RESET_ZERO;                            // R7
        else if (wr_mon)
            refbypass_disable_r <= wdata[REFBYPASS_DISABLE_BIT];
    end

    assign supply5_nominal_irq = nom_flag_r && nom_ie_r;      // R1
    assign supply5_high_irq    = high_flag_r && high_ie_r;    // R1
    assign supply5_reset_req   = nom_set && rst_en_r;         // R5
    assign converter_reference_bypass_pin = !refbypass_disable_r;        // R6

    // mode sequencer; every mode returns through run
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_r <= ST_RUN;                                 // R19
        end else begin
            case (state_r)
                ST_RUN:   if (cores_halted && (sleep_req_r || stop_req_r))
                              state_r <= ST_ENTER;             // R11
                ST_ENTER: state_r <= sleep_req_r ? ST_SLEEP : ST_STOP; // R11
                ST_SLEEP: if (wakeup) state_r <= ST_PWRUP;     // R12
                ST_STOP:  if (wakeup) state_r <= ST_RUN;       // R12
                // leave on the last count so reset stands exactly PWRUP_LEN cycles
                ST_PWRUP: if (pw_cnt_r <= 16'h0001) state_r <= ST_RUN;
                default:  state_r <= ST_RUN;
            endcase
        end
    end

    // power-up reset length count
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            pw_cnt_r <= 16'h0000;
        else if (state_r == ST_SLEEP)
            pw_cnt_r <= 16'(PWRUP_LEN);
        else if (pw_cnt_r != 16'h0000)
            pw_cnt_r <= pw_cnt_r - 16'h0001;
    end

    // request bits cleared on mode exit; ram select kept until the next power write
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sleep_req_r <= 1'b0;
            stop_req_r  <= 1'b0;
            retention_ram_select_r    <= 3'h0;
        end else begin
            if (state_r == ST_SLEEP && wakeup)
                sleep_req_r <= 1'b0;                           // R23
            else if (wr_pwr && state_r == ST_RUN)
                sleep_req_r <= wdata[SLEEP_REQ_BIT];
            if (state_r == ST_STOP && wakeup)
                stop_req_r <= 1'b0;                            // R23
            else if (wr_pwr && state_r == ST_RUN)
                stop_req_r <= wdata[STOP_REQ_BIT];
            if (wr_pwr)
                retention_ram_select_r <= wdata[RETENTION_RAM_SELECT_LSB +: RETENTION_RAM_SELECT_W];
        end
    end

    // recovery flags; set beats write-1 clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sleep_recovery_flag_r <= 1'b0;
            stopf_r  <= 1'b0;
        end else begin
            if (state_r == ST_SLEEP && wakeup)
                sleep_recovery_flag_r <= 1'b1;                              // R20
            else if (wr_pwr && wdata[SLEEP_RECOVERY_FLAG_BIT])
                sleep_recovery_flag_r <= 1'b0;
            if (state_r == ST_STOP && wakeup)
                stopf_r <= 1'b1;
            else if (wr_pwr && wdata[STOPF_BIT])
                stopf_r <= 1'b0;
        end
    end

    // pad keepers: entry relatches, stop exit frees, sleep waits for sw
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            keepers_r <= 1'b0;
        else if (state_r == ST_ENTER)
            keepers_r <= 1'b1;                                 // R9 R18
        else if (state_r == ST_STOP && wakeup)
            keepers_r <= 1'b0;                                 // R16
        else if (state_r == ST_RUN && wr_pwr && wdata[RELEASE_BIT])
            keepers_r <= 1'b0;                                 // R17
    end

    // latch pulse in entry cycle drops old hold first
    assign pad_latch          = (state_r == ST_ENTER);         // R9 R18
    assign pad_select_latched = keepers_r && (state_r != ST_ENTER); // R9
    assign pad_isolate        = keepers_r && (state_r != ST_ENTER); // R9
    assign sleep_power_off    = (state_r == ST_SLEEP);         // R8
    assign stop_static        = (state_r == ST_STOP);          // R8
    assign osc_clock_select   = (state_r != ST_RUN);           // R13
    assign crystal_run        = crystal_osc_enable &&
                                (state_r == ST_RUN);           // R22
    assign poweron_reset_out  = (state_r == ST_PWRUP);         // R20
    assign skip_boot          = sleep_recovery_flag_r;                      // R21
    assign retention_ram_select = retention_ram_select_r;

    // read data one cycle after strobe
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            rdata <= 32'h0000_0000;
            if (addr == ADDR_SUPPLY_MON) begin
                rdata[NOM_IE_BIT]    <= nom_ie_r;
                rdata[HIGH_IE_BIT]   <= high_ie_r;
                rdata[NOM_FLAG_BIT]  <= nom_flag_r;
                rdata[HIGH_FLAG_BIT] <= high_flag_r;
                rdata[LOCK_BIT]      <= lock_r;
                rdata[RST_EN_BIT]    <= rst_en_r;
                rdata[REFBYPASS_DISABLE_BIT]    <= refbypass_disable_r;
            end else if (addr == ADDR_POWER_CTRL) begin
                rdata[SLEEP_RECOVERY_FLAG_BIT]    <= sleep_recovery_flag_r;
                rdata[STOPF_BIT]     <= stopf_r;
                rdata[SLEEP_REQ_BIT] <= sleep_req_r;
                rdata[STOP_REQ_BIT]  <= stop_req_r;
                rdata[RELEASE_BIT]   <= 1'b0;                  // R24
                rdata[RETENTION_RAM_SELECT_LSB +: RETENTION_RAM_SELECT_W] <= retention_ram_select_r;
            end
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
endmodule // low_power_mode_sequencer
`default_nettype wire

// File: lpm_checker_props.sv
`default_nettype none
module lpm_checker
    import lpm_pkg::*;
#(
    parameter int PWRUP_LEN = 10  // power-up reset length
) (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [7:0]  addr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        sleep_power_off,
    input wire logic        stop_static,
    input wire logic        pad_latch,
    input wire logic        pad_select_latched,
    input wire logic        pad_isolate,
    input wire logic        osc_clock_select,
    input wire logic        crystal_run,
    input wire logic        poweron_reset_out,
    input wire logic        skip_boot
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire logic  low_pwr = sleep_power_off | stop_static;  // either mode
    logic [7:0] pwrup_cnt_r;  // power-up reset cycles so far
    // a counter, since the length is a parameter and too long to unroll
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            pwrup_cnt_r <= 8'h00;
        else if (poweron_reset_out)
            pwrup_cnt_r <= pwrup_cnt_r + 8'h01;
        else
            pwrup_cnt_r <= 8'h00;
    end
    a_latch_pulse: assert property (pad_latch |=> !pad_latch)
        else $error("pad latch longer than one cycle");
    a_latch_hold: assert property (pad_latch |=> pad_isolate && pad_select_latched)
        else $error("keepers not held after latch");
    a_modes_apart: assert property (!(sleep_power_off && stop_static))
        else $error("sleep and stop together");
    a_osc_lowpwr: assert property (low_pwr |-> osc_clock_select)
        else $error("low power without oscillator clock");
    a_crystal_off: assert property (low_pwr |-> !crystal_run)
        else $error("crystal runs in low power");
    a_pwrup_sleep: assert property ($rose(poweron_reset_out) |-> $past(sleep_power_off))
        else $error("power-up reset not from sleep");
    a_pwrup_len: assert property ($fell(poweron_reset_out) |-> pwrup_cnt_r == PWRUP_LEN)
        else $error("power-up reset length wrong");
    a_skip_boot: assert property ($fell(poweron_reset_out) |-> skip_boot)
        else $error("recovery does not skip boot");
    a_stop_free: assert property ($fell(stop_static) |-> ##[0:2] !pad_isolate)
        else $error("keepers held after stop");
    a_sleep_keep: assert property ($fell(sleep_power_off) |-> pad_isolate)
        else $error("keepers dropped on sleep exit");
    a_release_zero: assert property (
        $past(rd) && $past(addr) == ADDR_POWER_CTRL |-> !rdata[RELEASE_BIT])
        else $error("keeper release reads one");
    c_sleep: cover property ($rose(sleep_power_off));
    c_stop: cover property ($rose(stop_static));
    c_pwrup: cover property ($fell(poweron_reset_out));
endmodule // lpm_checker
bind low_power_mode_sequencer lpm_checker #(.PWRUP_LEN(PWRUP_LEN)) chk_i (
    .mclk(mclk), .reset(reset), .addr(addr), .rd(rd), .rdata(rdata),
    .sleep_power_off(sleep_power_off), .stop_static(stop_static), .pad_latch(pad_latch),
    .pad_select_latched(pad_select_latched), .pad_isolate(pad_isolate),
    .osc_clock_select(osc_clock_select), .crystal_run(crystal_run),
    .poweron_reset_out(poweron_reset_out), .skip_boot(skip_boot));
`default_nettype wire

// File: core_clock_model.sv
`default_nettype none
module core_clock_model #(
    parameter int DLY = 3  // cycles for the cores to drain
) (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic wait_exec,         // active cores ran wait
    input  wire logic osc_clock_select,  // controller owns the chip
    output var logic  cores_halted
);
    int cnt_r;  // halt countdown, 0 when idle
    // signal entry once drained, drop it when the controller takes over
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_r <= 0;
            cores_halted <= 1'h0;
        end else if (wait_exec) begin
            cnt_r <= DLY;
        end else if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1;
        end else if (cnt_r == 1) begin
            cnt_r <= 0;
            cores_halted <= 1'h1;
        end else if (osc_clock_select) begin
            cores_halted <= 1'h0;
        end
    end
endmodule // core_clock_model
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench
    import lpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, reset, sup_rst, s5_rst, wr, rd, wakeup, det_n, det_h, xen, wait_exec;
    logic        halted, n_irq, h_irq, rst_req, ref_pin, sleep_off, stop_st, latch;
    logic        pad_sel, pad_iso, osc_sel, xrun, por, skip;
    logic [2:0]  ram_sel;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rv;
    int          err_total, n_tests, cyc, rr_seen, latch_seen;
    low_power_mode_sequencer #(.PWRUP_LEN(2)) DUT (
        .mclk(mclk), .reset(reset), .supply_reset(sup_rst), .supply5_low_reset(s5_rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .det_nominal_low(det_n),
        .det_high_low(det_h), .cores_halted(halted), .wakeup(wakeup),
        .crystal_osc_enable(xen), .supply5_nominal_irq(n_irq), .supply5_high_irq(h_irq),
        .supply5_reset_req(rst_req), .converter_reference_bypass_pin(ref_pin),
        .sleep_power_off(sleep_off), .stop_static(stop_st), .pad_latch(latch),
        .pad_select_latched(pad_sel), .pad_isolate(pad_iso), .osc_clock_select(osc_sel),
        .crystal_run(xrun), .poweron_reset_out(por), .skip_boot(skip),
        .retention_ram_select(ram_sel));
    core_clock_model #(.DLY(4)) cores (.mclk(mclk), .reset(reset), .wait_exec(wait_exec),
        .osc_clock_select(osc_sel), .cores_halted(halted));
    // 100 ns clock
    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end
    // event counters and the hang limit
    always @(posedge mclk) begin
        cyc++;
        if (rst_req === 1'h1) rr_seen++;
        if (latch === 1'h1) latch_seen++;
        if (cyc == 3000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge mclk);
        wr <= 1'h0;
        @(negedge mclk);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'h1;
        @(posedge mclk);
        rd <= 1'h0;
        @(negedge mclk);
        rv = rdata;
    endtask
    // bounded wait for a settled low-power (1) or run (0) state
    task automatic wait_mode(input logic lp);
        for (int i = 0; i < 60; i++)
            if (!((sleep_off | stop_st) === lp && osc_sel === lp)) @(negedge mclk);
    endtask
    task automatic enter(input logic [31:0] req);
        wr_reg(ADDR_POWER_CTRL, req);
        wait_exec <= 1'h1;
        @(posedge mclk);
        wait_exec <= 1'h0;
        wait_mode(1'h1);
    endtask
    task automatic leave();
        @(posedge mclk);
        wakeup <= 1'h1;
        @(posedge mclk);
        wakeup <= 1'h0;
        wait_mode(1'h0);
    endtask
    // detector flags, enables and the reset request
    task automatic t_supply();
        rd_reg(ADDR_SUPPLY_MON);
        chk(rv, 32'h20, "monitor reset");
        chk({31'h0, ref_pin, xrun}, 32'h3, "pin, crystal");
        det_n <= 1'h1;
        repeat (5) @(posedge mclk);
        rd_reg(ADDR_SUPPLY_MON);
        chk(rv, 32'h24, "nominal set");
        chk({n_irq, rr_seen[30:0]}, 32'h1, "irq off, reset req");
        wr_reg(ADDR_SUPPLY_MON, 32'h21);
        rd_reg(ADDR_SUPPLY_MON);
        chk({rv[30:0], n_irq}, 32'h4B, "nominal w0, irq");
        det_n <= 1'h0;
        det_h <= 1'h1;
        repeat (5) @(posedge mclk);
        wr_reg(ADDR_SUPPLY_MON, 32'h25);
        rd_reg(ADDR_SUPPLY_MON);
        chk({rv[30:0], h_irq}, 32'h52, "high set");
        det_h <= 1'h0;
        wr_reg(ADDR_SUPPLY_MON, 32'h23);
        chk({31'h0, h_irq}, 32'h1, "high irq");
        wr_reg(ADDR_SUPPLY_MON, 32'h2B);
        rd_reg(ADDR_SUPPLY_MON);
        chk({rv[30:0], h_irq}, 32'h46, "high clear");
    endtask
    // lock, bypass pin and the supply detector resets
    task automatic t_lock();
        wr_reg(ADDR_SUPPLY_MON, 32'h03);
        wr_reg(ADDR_SUPPLY_MON, 32'h13);
        wr_reg(ADDR_SUPPLY_MON, 32'h33);
        det_n <= 1'h1;
        repeat (5) @(posedge mclk);
        rd_reg(ADDR_SUPPLY_MON);
        chk(rv, 32'h17, "locked enable");
        chk(rr_seen, 32'h1, "no reset req");
        det_n <= 1'h0;
        wr_reg(ADDR_SUPPLY_MON, 32'h8013);
        chk({31'h0, ref_pin}, 32'h0, "pin off");
        s5_rst <= 1'h1;
        @(posedge mclk);
        s5_rst <= 1'h0;
        rd_reg(ADDR_SUPPLY_MON);
        chk({rv[30:0] & 31'h8030, ref_pin}, 32'h21, "5 V reset");
        sup_rst <= 1'h1;
        @(posedge mclk);
        sup_rst <= 1'h0;
        rd_reg(ADDR_SUPPLY_MON);
        chk(rv & 32'h30, 32'h20, "supply reset");
    endtask
    // sleep wins, then stop re-entry with keepers still held
    task automatic t_modes();
        enter(32'h0053_0000);
        chk({sleep_off, stop_st, pad_iso, ram_sel}, 32'h2D, "sleep entry");
        leave();
        rd_reg(ADDR_POWER_CTRL);
        chk(rv, 32'h0052_0001, "after sleep");
        chk({skip, pad_iso}, 32'h3, "recovery");
        enter(32'h0052_0000);
        chk({stop_st, latch_seen[30:0]}, 32'h8000_0002, "stop relatch");
        leave();
        repeat (3) @(posedge mclk);
        chk({31'h0, pad_iso}, 32'h0, "stop release");
        rd_reg(ADDR_POWER_CTRL);
        chk(rv, 32'h0050_0003, "after stop");
        enter(32'h0001_0000);
        leave();
        chk({31'h0, pad_iso}, 32'h1, "held");
        wr_reg(ADDR_POWER_CTRL, 32'h0008_0000);
        rd_reg(ADDR_POWER_CTRL);
        chk({rv[30:0], pad_iso}, 32'h6, "released");
        enter(32'h0002_0000);
        reset <= 1'h1;
        @(posedge mclk);
        reset <= 1'h0;
        @(negedge mclk);
        chk({30'h0, stop_st, osc_sel}, 32'h0, "reset in stop");
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        {reset, sup_rst, s5_rst, wr, rd, wakeup, det_n, det_h, wait_exec} = 9'h100;
        {addr, wdata, xen} = 41'h1;
        repeat (3) @(posedge mclk);
        reset <= 1'h0;
        t_supply();
        t_lock();
        t_modes();
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
